// [rtl/fsl_pkg.sv]
// How it works
// - Green run lamp off in INIT
// - Green run lamp blinks in PRE-OPERATIONAL
// - Green run lamp single-flashes in SAFE-OPERATIONAL
// - Green run lamp steady on in OPERATIONAL
// - Red fault lamp off without errors
// - Invalid configuration blinks red lamp
// - Autonomous state change gives red single flash
// - Application watchdog gives red double flash
// - Linked idle port lamp steady on
// - Linked busy port lamp flickers with load
// - Port without link has lamp off
// - Yellow lamp always off
// - Blink is 200 ms on, 200 ms off
// - Single flash 200 ms on, 1000 ms off
// - Double flash two 200 ms flashes, 1000 off
// - Flicker 50/50 ms busy, irregular when light
package fsl_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_FREQ_HZ = 250_000_000; // System clock rate
    localparam int MS_PER_S = 1000; // Milliseconds in a second
    localparam int PH_W = 11; // Width of the phase counter in ms
    localparam logic [PH_W-1:0] T_BLINK_MS = 11'h0C8; // 200 ms
    localparam logic [PH_W-1:0] T_FLASH_MS = 11'h0C8; // 200 ms
    localparam logic [PH_W-1:0] T_LONG_OFF_MS = 11'h3E8; // 1000 ms
    localparam logic [PH_W-1:0] T_FLICK_MS = 11'h032; // 50 ms
    localparam logic [PH_W-1:0] BLINK_PERIOD_MS = PH_W'(2 * T_BLINK_MS);
    localparam logic [PH_W-1:0] SINGLE_PERIOD_MS =
        PH_W'(T_FLASH_MS + T_LONG_OFF_MS);
    localparam logic [PH_W-1:0] DOUBLE_ON2_MS = PH_W'(2 * T_FLASH_MS);
    localparam logic [PH_W-1:0] DOUBLE_PERIOD_MS =
        PH_W'(3 * T_FLASH_MS + T_LONG_OFF_MS);
    localparam logic [PH_W-1:0] FLICK_PERIOD_MS = PH_W'(2 * T_FLICK_MS);
    localparam logic [PH_W-1:0] ACT_HOLD_MS = FLICK_PERIOD_MS;

    // ----------------------------------------------------------------
    // Slave state codes as delivered by the protocol logic
    // ----------------------------------------------------------------
    localparam logic [3:0] ST_INIT = 4'h1;
    localparam logic [3:0] ST_PREOP = 4'h2;
    localparam logic [3:0] ST_SAFEOP = 4'h4;
    localparam logic [3:0] ST_OP = 4'h8;

    // ----------------------------------------------------------------
    // Register map (word index; byte address is four times it)
    // ----------------------------------------------------------------
    localparam logic [2:0] REG_CTRL = 3'h0; // Control
    localparam logic [2:0] REG_STATUS = 3'h1; // Live state, read only
    localparam logic [2:0] REG_IRQ_STATUS = 3'h2; // Sticky, W1C
    localparam logic [2:0] REG_IRQ_MASK = 3'h3; // Interrupt enables
    localparam int CTRL_EN_BIT = 0; // Lamps enabled
    localparam logic CTRL_RESET = 1'h1; // Lamps on after reset
    localparam int ST_STATE_LSB = 0; // Slave state field
    localparam int ST_ERR_LSB = 4; // Three error flags
    localparam int ST_LINK_LSB = 8; // Link flag per port
    localparam int ST_RUN_BIT = 16; // Green run lamp now
    localparam int ST_FAULT_BIT = 17; // Red fault lamp now
    localparam int IRQ_W = 3; // Number of interrupt events
    localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0; // Status and mask
    localparam int EV_STATE = 0; // Slave state changed
    localparam int EV_ERROR = 1; // An error flag rose
    localparam int EV_LINK = 2; // A link flag changed

    // ----------------------------------------------------------------
    // Lamp patterns, one-hot
    // ----------------------------------------------------------------
    typedef enum logic [5:0] {
        PAT_OFF = 6'h01,
        PAT_ON = 6'h02,
        PAT_BLINK = 6'h04,
        PAT_SINGLE = 6'h08,
        PAT_DOUBLE = 6'h10,
        PAT_FLICKER = 6'h20
    } fsl_pat_t;

endpackage

// [rtl/fsl_pattern.sv]
// One lamp: plays the selected pattern on the millisecond timebase
module fsl_pattern
    import fsl_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Timebase and pattern choice
    input wire logic ms_tick,
    input wire fsl_pat_t pattern,
    // Lamp drive
    output logic led
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    fsl_pat_t pat_prev_reg; // Pattern shown last cycle
    logic [PH_W-1:0] phase_reg; // Milliseconds into the period
    logic [PH_W-1:0] phase; // Phase with restart applied
    logic [PH_W-1:0] period; // Length of the current pattern
    logic restart; // Pattern changed this cycle
    logic lit; // Lamp on at this phase

    assign restart = (pattern != pat_prev_reg);
    // A new pattern starts at zero, which is an on phase for every pattern but PAT_OFF
    assign phase = restart ? '0 : phase_reg;

    // Remember the pattern to spot changes
    always_ff @(posedge clock) begin
        if (!resetn) begin
            pat_prev_reg <= PAT_OFF;
        end else begin
            pat_prev_reg <= pattern;
        end
    end

    // Period of each pattern, in milliseconds
    always_comb begin
        unique case (pattern)
            PAT_BLINK: period = BLINK_PERIOD_MS;
            PAT_SINGLE: period = SINGLE_PERIOD_MS;
            PAT_DOUBLE: period = DOUBLE_PERIOD_MS;
            PAT_FLICKER: period = FLICK_PERIOD_MS;
            default: period = 11'h001; // Steady patterns, no cycle
        endcase
    end

    // Phase advances once a millisecond and wraps at the period
    always_ff @(posedge clock) begin
        if (!resetn) begin
            phase_reg <= '0;
        end else if (ms_tick) begin
            phase_reg <= (phase >= PH_W'(period - 11'h001)) ? '0 :
                PH_W'(phase + 11'h001);
        end else begin
            phase_reg <= phase;
        end
    end

    // On windows of each pattern
    always_comb begin
        unique case (pattern)
            PAT_ON: lit = 1'b1;
            PAT_BLINK: lit = (phase < T_BLINK_MS);
            PAT_SINGLE: lit = (phase < T_FLASH_MS);
            PAT_DOUBLE: lit = (phase < T_FLASH_MS) ||
                ((phase >= DOUBLE_ON2_MS) &&
                 (phase < PH_W'(DOUBLE_ON2_MS + T_FLASH_MS)));
            PAT_FLICKER: lit = (phase < T_FLICK_MS);
            default: lit = 1'b0;
        endcase
    end

    // Lamp comes straight from a flip-flop, dark in reset
    always_ff @(posedge clock) begin
        if (!resetn) begin
            led <= 1'b0;
        end else begin
            led <= lit;
        end
    end

endmodule // fsl_pattern

// [rtl/fsl_led_indicator.sv]
// Status lamp controller for a real-time Ethernet slave card
module fsl_led_indicator
    import fsl_pkg::*;
#(
    parameter int NUM_PORTS = 2, // Ethernet ports, at most 8
    parameter int MS_CYCLES = CLK_FREQ_HZ / MS_PER_S // Clocks per ms
) (
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Avalon-MM slave
    input wire logic [2:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Protocol state and error flags
    input wire logic [3:0] slave_state,
    input wire logic err_invalid_cfg,
    input wire logic err_local,
    input wire logic err_app_wdog,
    // Per-port link and traffic flags
    input wire logic [NUM_PORTS-1:0] port_link,
    input wire logic [NUM_PORTS-1:0] port_activity,
    // Lamps
    output logic led_run_green,
    output logic led_fault_red,
    output logic [NUM_PORTS-1:0] led_link_green,
    output logic [NUM_PORTS-1:0] led_unused_yellow,
    // Interrupt
    output logic irq
);

    // ----------------------------------------------------------------
    // Millisecond timebase
    // ----------------------------------------------------------------
    localparam int TB_W = $clog2(MS_CYCLES);
    localparam logic [TB_W-1:0] TB_LAST = TB_W'(MS_CYCLES - 1);

    logic [TB_W-1:0] tb_count_reg; // Clocks into the current ms
    logic ms_tick_reg; // One-cycle pulse per millisecond

    // Divider from the system clock; every pattern shares it
    always_ff @(posedge clock) begin
        if (!resetn) begin
            tb_count_reg <= '0;
            ms_tick_reg <= 1'b0;
        end else if (tb_count_reg == TB_LAST) begin
            tb_count_reg <= '0;
            ms_tick_reg <= 1'b1;
        end else begin
            tb_count_reg <= TB_W'(tb_count_reg + 1'b1);
            ms_tick_reg <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Bus slave
    // ----------------------------------------------------------------
    logic ctrl_en_reg; // Lamps enabled by software
    logic [IRQ_W-1:0] irq_status_reg; // Sticky events
    logic [IRQ_W-1:0] irq_mask_reg; // Event enables
    logic wait_reg; // Drives waitrequest
    logic [31:0] rdata_reg; // Drives readdata
    logic [31:0] status_word; // Live state as software sees it
    logic [31:0] read_word; // Word chosen by the address
    logic access; // Request present
    logic wr_take; // Write takes effect this edge
    logic lane0; // Low byte lane enabled

    assign access = avs_read || avs_write;
    // A request is finished on the edge where waitrequest is low
    assign wr_take = avs_write && !wait_reg;
    // All fields live in the low byte except STATUS, which is read only
    assign lane0 = avs_byteenable[0];

    // Waitrequest is high by default and drops for exactly one cycle
    // after a request has been seen, giving a fixed one-wait answer.
    always_ff @(posedge clock) begin
        if (!resetn) begin
            wait_reg <= 1'b1;
        end else if (access && wait_reg) begin
            wait_reg <= 1'b0;
        end else begin
            wait_reg <= 1'b1;
        end
    end

    // Live state word
    always_comb begin
        status_word = '0;
        status_word[ST_STATE_LSB +: 4] = slave_state;
        status_word[ST_ERR_LSB] = err_invalid_cfg;
        status_word[ST_ERR_LSB + 1] = err_local;
        status_word[ST_ERR_LSB + 2] = err_app_wdog;
        status_word[ST_LINK_LSB +: NUM_PORTS] = port_link;
        status_word[ST_RUN_BIT] = led_run_green;
        status_word[ST_FAULT_BIT] = led_fault_red;
    end

    // Read multiplexer; unmapped addresses read zero
    always_comb begin
        read_word = '0;
        unique case (avs_address)
            REG_CTRL: read_word[CTRL_EN_BIT] = ctrl_en_reg;
            REG_STATUS: read_word = status_word;
            REG_IRQ_STATUS: read_word[IRQ_W-1:0] = irq_status_reg;
            REG_IRQ_MASK: read_word[IRQ_W-1:0] = irq_mask_reg;
            default: read_word = '0;
        endcase
    end

    // Read data is captured while waitrequest is still high, so it is
    // stable on the edge where the master takes it.
    always_ff @(posedge clock) begin
        if (!resetn) begin
            rdata_reg <= '0;
        end else if (avs_read && wait_reg) begin
            rdata_reg <= read_word;
        end
    end

    // Control register: disabling darkens every lamp
    always_ff @(posedge clock) begin
        if (!resetn) begin
            ctrl_en_reg <= CTRL_RESET;
        end else if (wr_take && lane0 && avs_address == REG_CTRL) begin
            ctrl_en_reg <= avs_writedata[CTRL_EN_BIT];
        end
    end

    // Interrupt mask
    always_ff @(posedge clock) begin
        if (!resetn) begin
            irq_mask_reg <= IRQ_RESET;
        end else if (wr_take && lane0 && avs_address == REG_IRQ_MASK) begin
            irq_mask_reg <= avs_writedata[IRQ_W-1:0];
        end
    end

    // ----------------------------------------------------------------
    // Events and interrupt
    // ----------------------------------------------------------------
    logic [3:0] state_prev_reg; // Slave state last cycle
    logic [2:0] err_prev_reg; // Error flags last cycle
    logic [NUM_PORTS-1:0] link_prev_reg; // Link flags last cycle
    logic [2:0] err_now; // Error flags gathered
    logic [IRQ_W-1:0] events; // Events this cycle
    logic [IRQ_W-1:0] irq_clear; // Bits software clears

    assign err_now = {err_app_wdog, err_local, err_invalid_cfg};

    // Previous values, for edge detection
    always_ff @(posedge clock) begin
        if (!resetn) begin
            state_prev_reg <= ST_INIT;
            err_prev_reg <= '0;
            link_prev_reg <= '0;
        end else begin
            state_prev_reg <= slave_state;
            err_prev_reg <= err_now;
            link_prev_reg <= port_link;
        end
    end

    // Event sources
    always_comb begin
        events = '0;
        events[EV_STATE] = (slave_state != state_prev_reg);
        events[EV_ERROR] = |(err_now & ~err_prev_reg);
        events[EV_LINK] = (port_link != link_prev_reg);
    end

    // Write one to clear
    assign irq_clear = (wr_take && lane0 && avs_address == REG_IRQ_STATUS)
        ? avs_writedata[IRQ_W-1:0] : '0;

    // Sticky status; a new event in the clearing cycle is kept
    always_ff @(posedge clock) begin
        if (!resetn) begin
            irq_status_reg <= IRQ_RESET;
        end else begin
            irq_status_reg <= (irq_status_reg & ~irq_clear) | events;
        end
    end

    // Level interrupt, one cycle behind the status bits
    always_ff @(posedge clock) begin
        if (!resetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status_reg & irq_mask_reg);
        end
    end

    // ----------------------------------------------------------------
    // Green run lamp
    // ----------------------------------------------------------------
    fsl_pat_t run_pat; // Pattern for the run lamp

    // Unknown or bootstrap state codes leave the lamp dark
    always_comb begin
        run_pat = PAT_OFF;
        if (ctrl_en_reg) begin
            unique case (slave_state)
                ST_INIT: run_pat = PAT_OFF;
                ST_PREOP: run_pat = PAT_BLINK;
                ST_SAFEOP: run_pat = PAT_SINGLE;
                ST_OP: run_pat = PAT_ON;
                default: run_pat = PAT_OFF;
            endcase
        end
    end

    fsl_pattern u_run (
        .clock(clock),
        .resetn(resetn),
        .ms_tick(ms_tick_reg),
        .pattern(run_pat),
        .led(led_run_green)
    );

    // ----------------------------------------------------------------
    // Red fault lamp
    // ----------------------------------------------------------------
    fsl_pat_t fault_pat; // Pattern for the fault lamp

    // Several errors at once: the watchdog wins, then the local error,
    // then the configuration error, so the most urgent one is shown.
    always_comb begin
        fault_pat = PAT_OFF;
        if (ctrl_en_reg) begin
            if (err_app_wdog) begin
                fault_pat = PAT_DOUBLE;
            end else if (err_local) begin
                fault_pat = PAT_SINGLE;
            end else if (err_invalid_cfg) begin
                fault_pat = PAT_BLINK;
            end
        end
    end

    fsl_pattern u_fault (
        .clock(clock),
        .resetn(resetn),
        .ms_tick(ms_tick_reg),
        .pattern(fault_pat),
        .led(led_fault_red)
    );

    // ----------------------------------------------------------------
    // Link and activity lamps, one per port
    // ----------------------------------------------------------------
    // Each traffic pulse keeps the port flickering for one full flicker
    // period. Constant traffic re-arms the hold before it runs out, so
    // the lamp runs a steady 10 Hz; sparse traffic gives one off blink
    // per burst at irregular times. A short burst is never lost, at
    // the price of up to 100 ms of extra flicker after it.
    genvar gp;
    generate
        for (gp = 0; gp < NUM_PORTS; gp++) begin : g_port
            logic [PH_W-1:0] hold_reg; // Ms of flicker left
            fsl_pat_t link_pat; // Pattern for this port

            // Activity hold counter
            always_ff @(posedge clock) begin
                if (!resetn) begin
                    hold_reg <= '0;
                end else if (port_activity[gp] && port_link[gp]) begin
                    hold_reg <= ACT_HOLD_MS;
                end else if (!port_link[gp]) begin
                    hold_reg <= '0;
                end else if (ms_tick_reg && hold_reg != '0) begin
                    hold_reg <= PH_W'(hold_reg - 11'h001);
                end
            end

            // Link decides on or off, traffic adds the flicker
            always_comb begin
                if (!ctrl_en_reg || !port_link[gp]) begin
                    link_pat = PAT_OFF;
                end else if (port_activity[gp] || hold_reg != '0) begin
                    link_pat = PAT_FLICKER;
                end else begin
                    link_pat = PAT_ON;
                end
            end

            fsl_pattern u_link (
                .clock(clock),
                .resetn(resetn),
                .ms_tick(ms_tick_reg),
                .pattern(link_pat),
                .led(led_link_green[gp])
            );

            // Yellow lamp has no use here and stays dark
            always_ff @(posedge clock) begin
                if (!resetn) begin
                    led_unused_yellow[gp] <= 1'b0;
                end else begin
                    led_unused_yellow[gp] <= 1'b0;
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Bus outputs
    // ----------------------------------------------------------------
    assign avs_waitrequest = wait_reg;
    assign avs_readdata = rdata_reg;

endmodule // fsl_led_indicator

// [testbench/fsl_led_checker.sv]
module fsl_led_checker
    import fsl_pkg::*;
#(
    parameter int NUM_PORTS = 2,
    parameter int MS_CYCLES = 10
) (
    // Clock, reset and bus
    input wire logic clock,
    input wire logic resetn,
    input wire logic [2:0] avs_address,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic avs_waitrequest,
    // Status inputs
    input wire logic [3:0] slave_state,
    input wire logic err_invalid_cfg,
    input wire logic err_local,
    input wire logic err_app_wdog,
    input wire logic [NUM_PORTS-1:0] port_link,
    input wire logic [NUM_PORTS-1:0] port_activity,
    // Lamps
    input wire logic led_run_green,
    input wire logic led_fault_red,
    input wire logic [NUM_PORTS-1:0] led_link_green,
    input wire logic [NUM_PORTS-1:0] led_unused_yellow
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    logic [1:0] up; // Cycles since reset, saturating
    logic en; // Shadow of the lamp enable bit
    logic [3:0] st_q; // Slave state one cycle ago
    logic [2:0] er_q; // Error flags one cycle ago
    int run_on, flt_on, idle; // Lit and idle run lengths
    wire logic [2:0] er = {err_app_wdog, err_local, err_invalid_cfg};
    // Lengths restart when their cause changes, so a stale run never counts
    always_ff @(posedge clock) begin
        if (!resetn) begin
            up <= 2'h0;
            en <= 1'h1;
            run_on <= 0;
            flt_on <= 0;
            idle <= 0;
        end else begin
            if (up != 2'h3) begin
                up <= up + 2'h1;
            end
            if (avs_write && !avs_waitrequest && avs_address == REG_CTRL
                && avs_byteenable[0]) begin
                en <= avs_writedata[CTRL_EN_BIT];
            end
            run_on <= (led_run_green && slave_state == st_q) ?
                run_on + 1 : 0;
            flt_on <= (led_fault_red && er == er_q) ? flt_on + 1 : 0;
            idle <= (port_activity[0] || !port_link[0]) ? 0 : idle + 1;
        end
        st_q <= slave_state;
        er_q <= er;
    end
    yellow_off_a: assert property (led_unused_yellow == '0)
        else $error("yellow lamp lit");
    init_off_a: assert property (slave_state == ST_INIT |=>
        !led_run_green) else $error("run lamp lit in init");
    op_on_a: assert property (up == 2'h3 && slave_state == ST_OP
        && en && $past(en) |=> led_run_green) else $error("run lamp dark");
    link_off_a: assert property (!port_link[0] |=>
        !led_link_green[0]) else $error("link lamp lit without link");
    link_on_a: assert property (up == 2'h3 && en && $past(en)
        && port_link[0] && idle > 101 * MS_CYCLES + 2 |=> led_link_green[0])
        else $error("idle link lamp dark");
    fault_off_a: assert property (up == 2'h3 && er == 3'h0
        && er_q == 3'h0 |=> !led_fault_red) else $error("fault lamp lit");
    blink_len_a: assert property (slave_state == ST_PREOP
        && st_q == ST_PREOP |-> run_on <= 200 * MS_CYCLES + 1)
        else $error("blink on phase too long");
    double_len_a: assert property (err_app_wdog && er == er_q
        |-> flt_on <= 200 * MS_CYCLES + 1)
        else $error("flash on phase too long");
endmodule // fsl_led_checker

bind fsl_led_indicator fsl_led_checker #(
    .NUM_PORTS(NUM_PORTS), .MS_CYCLES(MS_CYCLES)
) fsl_led_checker_i (
    .clock(clock), .resetn(resetn), .avs_address(avs_address),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_waitrequest(avs_waitrequest),
    .slave_state(slave_state), .err_invalid_cfg(err_invalid_cfg),
    .err_local(err_local), .err_app_wdog(err_app_wdog),
    .port_link(port_link), .port_activity(port_activity),
    .led_run_green(led_run_green), .led_fault_red(led_fault_red),
    .led_link_green(led_link_green),
    .led_unused_yellow(led_unused_yellow)
);

// [testbench/fsl_lamp_watch.sv]
// Front-panel lamp as an operator sees it: times each lit phase
module fsl_lamp_watch (
    // Clock and lamp
    input wire logic clock,
    input wire logic lamp,
    // Length of the last completed lit phase, in clocks
    output int last_on
);
    timeunit 1ns;
    timeprecision 1ps;
    int run = 0; // Clocks lit so far
    initial last_on = 0;
    // A phase ends on the first dark sample; unknown counts as dark
    always @(posedge clock) begin
        if (lamp === 1'b1) begin
            run <= run + 1;
        end else begin
            if (run != 0) begin
                last_on <= run;
            end
            run <= 0;
        end
    end
endmodule // fsl_lamp_watch

// [testbench/fsl_led_indicator_tb.sv]
module fsl_led_indicator_tb
    import fsl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MS = 10; // Clocks per ms tick, shortened for speed
    logic clock, resetn, rd, wr, e_cfg, e_loc, e_wd, wait_q, run_l, flt_l;
    logic irq;
    logic [2:0] addr;
    logic [31:0] wdata, rdata;
    logic [3:0] state;
    logic [1:0] link, act, link_l, yel_l;
    int last_run, last_link, n_mismatch = 0, checks_done = 0, cyc = 0;
    fsl_led_indicator #(.NUM_PORTS(2), .MS_CYCLES(MS)) fsl_led_indicator_i (
        .clock(clock), .resetn(resetn), .avs_address(addr),
        .avs_read(rd), .avs_write(wr), .avs_writedata(wdata),
        .avs_byteenable(4'hF), .avs_readdata(rdata),
        .avs_waitrequest(wait_q), .slave_state(state),
        .err_invalid_cfg(e_cfg), .err_local(e_loc), .err_app_wdog(e_wd),
        .port_link(link), .port_activity(act), .led_run_green(run_l),
        .led_fault_red(flt_l), .led_link_green(link_l),
        .led_unused_yellow(yel_l), .irq(irq));
    fsl_lamp_watch fsl_lamp_watch_i (.clock(clock), .lamp(run_l),
        .last_on(last_run));
    fsl_lamp_watch fsl_lamp_watch_link_i (.clock(clock), .lamp(link_l[0]),
        .last_on(last_link));
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("mismatches %0d, checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Holds the request until waitrequest is seen low, bounded
    task automatic bus(input logic w, input logic [2:0] a,
        input logic [31:0] d, output logic [31:0] q);
        int n = 0;
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= !w;
        do begin
            @(posedge clock);
            n++;
        end while (wait_q !== 1'b0 && n < 50);
        q = rdata;
        check("bus answer", {31'h0, wait_q}, 32'h0);
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge clock);
    endtask
    task automatic reg_chk(input logic [2:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check($sformatf("register %0d", a), q, exp);
    endtask
    task automatic wr_reg(input logic [2:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic wait_ms(input int ms);
        repeat (ms * MS) @(posedge clock);
    endtask
    // Samples a lamp mid-slot, so a short first phase cannot mislead
    task automatic lamp_seq(input int which, input int step, input int n,
        input logic [31:0] bits);
        logic l;
        wait_ms(step / 2);
        for (int k = n - 1; k >= 0; k--) begin
            l = (which == 0) ? run_l : (which == 1) ? flt_l : link_l[0];
            check($sformatf("lamp %0d slot %0d", which, k), {31'h0, l},
                {31'h0, bits[k]});
            wait_ms(step);
        end
    endtask
    // ----------------------------------------------------------------
    // Clock, timeout and main sequence
    // ----------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    // Whole run is about 90000 cycles
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 100000) begin
            n_mismatch++;
            finish_test();
        end
    end
    initial begin
        resetn = 1'b0;
        {rd, wr, e_cfg, e_loc, e_wd} = 5'h0;
        addr = 3'h0;
        wdata = 32'h0;
        state = ST_INIT;
        link = 2'h0;
        act = 2'h0;
        repeat (6) @(posedge clock);
        resetn <= 1'b1;
        @(posedge clock);
        check("lamps after reset", {28'h0, run_l, flt_l, link_l},
            32'h0);
        reg_chk(REG_CTRL, 32'h1);
        reg_chk(REG_IRQ_MASK, 32'h0);
        reg_chk(3'h5, 32'h0);
        lamp_seq(0, 100, 2, 2'h0);
        lamp_seq(1, 100, 2, 2'h0);
        lamp_seq(2, 100, 2, 2'h0);
        state <= ST_PREOP;
        lamp_seq(0, 100, 8, 8'hCC);
        check("blink on phase", last_run, 200 * MS);
        check("masked irq", {31'h0, irq}, 32'h0);
        reg_chk(REG_IRQ_STATUS, 32'h1);
        wr_reg(REG_IRQ_MASK, 32'h7);
        wait_ms(1);
        check("irq raised", {31'h0, irq}, 32'h1);
        wr_reg(REG_IRQ_STATUS, 32'h1);
        wait_ms(1);
        check("irq cleared", {31'h0, irq}, 32'h0);
        reg_chk(REG_IRQ_STATUS, 32'h0);
        state <= ST_SAFEOP;
        lamp_seq(0, 100, 14, 14'h3003);
        state <= ST_OP;
        lamp_seq(0, 100, 3, 3'h7);
        reg_chk(REG_STATUS, 32'h10008);
        wr_reg(REG_CTRL, 32'h0);
        wait_ms(1);
        check("disabled run lamp", {31'h0, run_l}, 32'h0);
        wr_reg(REG_CTRL, 32'h1);
        e_cfg <= 1'b1;
        lamp_seq(1, 100, 6, 6'h33);
        e_loc <= 1'b1;
        lamp_seq(1, 100, 14, 14'h3003);
        e_wd <= 1'b1;
        lamp_seq(1, 100, 18, 18'h33003);
        {e_cfg, e_loc, e_wd} <= 3'h0;
        lamp_seq(1, 100, 2, 2'h0);
        link <= 2'h1;
        lamp_seq(2, 100, 3, 3'h7);
        act <= 2'h1;
        lamp_seq(2, 50, 8, 8'hAA);
        check("flicker on phase", last_link, 50 * MS);
        act <= 2'h0;
        wait_ms(150);
        lamp_seq(2, 100, 2, 2'h3);
        link <= 2'h0;
        lamp_seq(2, 100, 2, 2'h0);
        reg_chk(REG_IRQ_STATUS, 32'h7);
        check("yellow lamps", {30'h0, yel_l}, 32'h0);
        finish_test();
    end
endmodule // fsl_led_indicator_tb
